/* File: logic/tbuf_pkg.sv */
package tbuf_pkg;
    // ****************************************************************
    // Register map and fields.
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_DATAH = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_TSE_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_LOCK_BIT = 4;
    localparam int CTRL_SEC_BIT = 5;
    localparam int CNT_ROLL_BIT = 15;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic TSE_RST = 1'b0;
    localparam logic LOCK_RST = 1'b1;
    // ****************************************************************
    // Trace modes, row codes and carriers.
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_LOOP = 2'b01,
        MODE_DETAIL = 2'b10,
        MODE_COMP = 2'b11
    } trace_mode_e;
    localparam trace_mode_e MODE_RST = MODE_NORMAL;
    localparam logic [1:0] CODE_BASE = 2'b00;
    localparam logic [1:0] CODE_ONE = 2'b01;
    localparam logic [1:0] CODE_TWO = 2'b10;
    localparam logic [1:0] CODE_THREE = 2'b11;
    localparam logic [3:0] FE_ALL = 4'hf;
    typedef struct packed {
        logic valid;
        logic stop;
        logic [17:0] addr;
        logic [15:0] data;
        logic rd;
        logic is_byte;
        logic dest;
        logic vect;
    } trace_in_s;
    typedef struct packed {
        logic wr;
        logic new_line;
        logic [3:0] fe;
        logic [19:0] row;
    } row_wr_s;
endpackage : tbuf_pkg

/* File: logic/tbuf_ram.sv */
`timescale 1ns/100ps
module tbuf_ram #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk, // System clock.
    input wire logic wr_en, // Write strobe.
    input wire logic [AW-1:0] wr_addr, // Line written.
    input wire logic [3:0] fe, // Field write enables.
    input wire logic [19:0] wdata, // Row to write.
    input wire logic [AW-1:0] rd_addr, // Line read.
    output logic [19:0] rdata // Row read, combinational.
);
    // ****************************************************************
    // One array per field so a partial row keeps its older fields.
    // ****************************************************************
    // No reset on purpose: the contents must survive a system reset.
    for (genvar g = 0; g < 4; g++)
    begin : g_seg
        localparam int LO = g * 6;
        localparam int HI = (g == 3) ? 19 : g * 6 + 5;
        logic [HI-LO:0] seg_mem [DEPTH];
        always_ff @(posedge clk)
        begin
            if (wr_en && fe[g])
                seg_mem[wr_addr] <= wdata[HI:LO];
        end
        assign rdata[HI:LO] = seg_mem[rd_addr];
    end
endmodule : tbuf_ram

/* File: logic/tbuf_pc_comp.sv */
`timescale 1ns/100ps
module tbuf_pc_comp (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic start, // New session pulse.
    input wire logic pc_valid, // Executed opcode strobe.
    input wire logic [17:0] pc, // Opcode address.
    input wire logic at_line0, // Next new line would be line zero.
    output tbuf_pkg::row_wr_s wr, // Row write request.
    output logic open_partial // Open row has free fields.
);
    import tbuf_pkg::*;
    logic [11:0] base_r;
    logic base_ok_r;
    logic [1:0] slots_r;
    logic need_base;
    logic open_new;
    logic take_base;

    // Pick the row form; a new line at line zero must be a base row.
    always_comb
    begin
        need_base = !base_ok_r || (pc[17:6] != base_r);
        open_new = (slots_r == 2'd0) || (slots_r == 2'd3) || need_base;
        take_base = need_base || (open_new && at_line0);
        wr = '0;
        wr.wr = pc_valid;
        wr.new_line = open_new;
        if (take_base)
        begin
            wr.fe = FE_ALL;
            wr.row = {CODE_BASE, pc};
        end
        else if (open_new)
        begin
            wr.fe = 4'h9;
            wr.row = {CODE_ONE, 12'h000, pc[5:0]};
        end
        else if (slots_r == 2'd1)
        begin
            wr.fe = 4'ha;
            wr.row = {CODE_TWO, 6'h00, pc[5:0], 6'h00};
        end
        else
        begin
            wr.fe = 4'hc;
            wr.row = {CODE_THREE, pc[5:0], 12'h000};
        end
    end

    // Base range and fill level of the open row.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_r <= 12'h000;
            base_ok_r <= 1'b0;
            slots_r <= 2'd0;
        end
        else if (start)
        begin
            base_ok_r <= 1'b0;
            slots_r <= 2'd0;
        end
        else if (pc_valid)
        begin
            if (take_base)
            begin
                base_r <= pc[17:6];
                base_ok_r <= 1'b1;
                slots_r <= 2'd0;
            end
            else if (open_new)
                slots_r <= 2'd1;
            else
                slots_r <= slots_r + 2'd1;
        end
    end

    // An open row still holding older fields is the oldest line after a wrap.
    assign open_partial = (slots_r == 2'd1) || (slots_r == 2'd2);
endmodule : tbuf_pc_comp

/* File: logic/trace_buffer_format_readout.sv */
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module trace_buffer_format_readout #(
    parameter int DEPTH = 64
) (
    input wire logic MCLK, // System clock.
    input wire logic RESET_N, // Asynchronous reset, active low.
    input wire logic HSEL, // Slave select.
    input wire logic [31:0] HADDR, // Byte address.
    input wire logic [1:0] HTRANS, // Transfer type.
    input wire logic HWRITE, // Write when high.
    input wire logic [2:0] HSIZE, // Transfer size.
    input wire logic [31:0] HWDATA, // Write data.
    input wire logic HREADY, // Bus ready.
    input wire tbuf_pkg::trace_in_s TRACE_IN, // Core capture port.
    input wire logic SECURED, // System secured, blocks data port reads.
    output logic [31:0] HRDATA, // Read data.
    output logic HREADYOUT, // Slave ready.
    output logic HRESP, // Always OKAY.
    output logic ARMED // Capture session running.
);
    import tbuf_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    // ****************************************************************
    // Bus address phase.
    // ****************************************************************
    logic pend_r;
    logic a_wr_r;
    logic a_word_r;
    logic [7:0] a_ofs_r;
    logic hready_r;
    logic hresp_r;
    logic [31:0] hrdata_r;

    // One wait state lets the read data come from a flip-flop.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            pend_r <= 1'b0;
            a_wr_r <= 1'b0;
            a_word_r <= 1'b0;
            a_ofs_r <= 8'h00;
        end
        else if (HSEL && HTRANS[1] && HREADY)
        begin
            pend_r <= 1'b1;
            a_wr_r <= HWRITE;
            a_word_r <= (HSIZE == HSIZE_WORD) && (HADDR[1:0] == 2'b00);
            a_ofs_r <= HADDR[7:0];
        end
        else
            pend_r <= 1'b0;
    end

    // Ready drops for the first data-phase cycle only.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            hready_r <= 1'b1;
            hresp_r <= 1'b0;
        end
        else
        begin
            hready_r <= !(HSEL && HTRANS[1] && HREADY);
            hresp_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Decoded accesses.
    // ****************************************************************
    logic wr_ctrl;
    logic wr_data;
    logic wr_datah;
    logic rd_data;

    assign wr_ctrl = pend_r && a_wr_r && (a_ofs_r == OFS_CTRL);
    assign wr_data = pend_r && a_wr_r && a_word_r && (a_ofs_r == OFS_DATA);
    assign wr_datah = pend_r && a_wr_r && a_word_r && (a_ofs_r == OFS_DATAH);
    assign rd_data = pend_r && !a_wr_r && (a_ofs_r == OFS_DATA);

    // ****************************************************************
    // Control state.
    // ****************************************************************
    logic arm_r;
    logic tse_r;
    trace_mode_e mode_r;
    logic lock_r;
    logic sess_start;

    assign sess_start = wr_ctrl && HWDATA[CTRL_ARM_BIT] && !arm_r;

    // A software write wins over a stop arriving in the same cycle.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            arm_r <= 1'b0;
            tse_r <= TSE_RST;
            mode_r <= MODE_RST;
        end
        else if (wr_ctrl)
        begin
            arm_r <= HWDATA[CTRL_ARM_BIT];
            tse_r <= HWDATA[CTRL_TSE_BIT];
            mode_r <= trace_mode_e'(HWDATA[CTRL_MODE_LSB +: 2]);
        end
        else if (TRACE_IN.stop)
            arm_r <= 1'b0;
    end

    // Arming locks; only a word write to the data port while disarmed opens.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            lock_r <= LOCK_RST;
        else if (wr_ctrl && HWDATA[CTRL_ARM_BIT])
            lock_r <= 1'b1;
        else if (wr_data && !arm_r)
            lock_r <= 1'b0;
    end

    // ****************************************************************
    // Capture formatting.
    // ****************************************************************
    logic cap;
    logic det_pend_r;
    logic [19:0] det_row_r;
    logic [17:0] last_src_r;
    logic last_ok_r;
    logic loop_dup;
    row_wr_s cmp_wr;
    row_wr_s wr;
    logic open_partial;
    logic [AW-1:0] wptr_r;
    logic [CW-1:0] count_r;
    logic roll_r;

    // A detail data line occupies the cycle after its address line.
    assign cap = arm_r && tse_r && TRACE_IN.valid && !det_pend_r;
    assign loop_dup = (mode_r == MODE_LOOP) && !TRACE_IN.dest && !TRACE_IN.vect
        && last_ok_r && (TRACE_IN.addr == last_src_r);

    // Second line of a detail entry, byte data kept in the low byte.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            det_pend_r <= 1'b0;
            det_row_r <= 20'h00000;
        end
        else
        begin
            det_pend_r <= cap && (mode_r == MODE_DETAIL);
            if (TRACE_IN.is_byte)
                det_row_r <= {12'h000, TRACE_IN.data[7:0]};
            else
                det_row_r <= {4'h0, TRACE_IN.data};
        end
    end

    // Last stored address, used to drop repeated loop branches.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            last_src_r <= 18'h00000;
            last_ok_r <= 1'b0;
        end
        else if (sess_start)
            last_ok_r <= 1'b0;
        else if (cap && (mode_r == MODE_LOOP) && !loop_dup)
        begin
            last_src_r <= TRACE_IN.addr;
            last_ok_r <= 1'b1;
        end
    end

    tbuf_pc_comp u_comp (
        .clk(MCLK),
        .rst_n(RESET_N),
        .start(sess_start),
        .pc_valid(cap && (mode_r == MODE_COMP)),
        .pc(TRACE_IN.addr),
        .at_line0(wptr_r == '0),
        .wr(cmp_wr),
        .open_partial(open_partial)
    );

    // Row write request for the current mode.
    always_comb
    begin
        wr = '0;
        if (det_pend_r)
        begin
            wr.wr = 1'b1;
            wr.new_line = 1'b1;
            wr.fe = FE_ALL;
            wr.row = det_row_r;
        end
        else if (mode_r == MODE_COMP)
            wr = cmp_wr;
        else if (mode_r == MODE_DETAIL)
        begin
            wr.wr = cap;
            wr.new_line = 1'b1;
            wr.fe = FE_ALL;
            wr.row = {TRACE_IN.is_byte, TRACE_IN.rd, TRACE_IN.addr};
        end
        else
        begin
            wr.wr = cap && !loop_dup;
            wr.new_line = 1'b1;
            wr.fe = FE_ALL;
            // A vector is always a destination.
            wr.row = {TRACE_IN.dest || TRACE_IN.vect, TRACE_IN.vect,
                TRACE_IN.addr};
        end
    end

    // ****************************************************************
    // Write pointer, line count and wrap flag.
    // ****************************************************************
    // No reset here: a system reset must not lose the last session.
    always_ff @(posedge MCLK)
    begin
        if (sess_start)
        begin
            wptr_r <= '0;
            count_r <= '0;
            roll_r <= 1'b0;
        end
        else if (wr.wr && wr.new_line)
        begin
            wptr_r <= AW'((wptr_r + 1'b1) % DEPTH);
            if (count_r != FULL)
                count_r <= count_r + 1'b1;
            if (wptr_r == AW'(DEPTH - 1))
                roll_r <= 1'b1;
        end
    end

    // ****************************************************************
    // Storage.
    // ****************************************************************
    logic [AW-1:0] rptr_r;
    logic half_r;
    logic [19:0] rd_row;
    logic [AW-1:0] oldest;
    logic read_ok;

    tbuf_ram #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_ram (
        .clk(MCLK),
        .wr_en(wr.wr),
        .wr_addr(wr.new_line ? wptr_r : wptr_r - 1'b1),
        .fe(wr.fe),
        .wdata(wr.row),
        .rd_addr(rptr_r),
        .rdata(rd_row)
    );

    // ****************************************************************
    // Readout.
    // ****************************************************************
    // A partly refilled compressed row still holds the oldest fields.
    always_comb
    begin
        if (!roll_r)
            oldest = '0;
        else if ((mode_r == MODE_COMP) && open_partial)
            oldest = wptr_r - 1'b1;
        else
            oldest = wptr_r;
    end

    assign read_ok = !arm_r && tse_r && !SECURED && !lock_r && a_word_r;

    // Read pointer: rewound by unlock or high-port write, stepped per line.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rptr_r <= '0;
            half_r <= 1'b0;
        end
        else if ((wr_data && !arm_r) || wr_datah)
        begin
            rptr_r <= oldest;
            half_r <= 1'b0;
        end
        else if (rd_data && read_ok)
        begin
            half_r <= !half_r;
            if (half_r)
                rptr_r <= AW'((rptr_r + 1'b1) % DEPTH);
        end
    end

    // Read data, zero where reads are refused.
    always_ff @(posedge MCLK or negedge RESET_N)
    begin
        if (!RESET_N)
            hrdata_r <= 32'h00000000;
        else if (pend_r && !a_wr_r)
        begin
            hrdata_r <= 32'h00000000;
            case (a_ofs_r)
                OFS_CTRL:
                begin
                    hrdata_r[CTRL_ARM_BIT] <= arm_r;
                    hrdata_r[CTRL_TSE_BIT] <= tse_r;
                    hrdata_r[CTRL_MODE_LSB +: 2] <= mode_r;
                    hrdata_r[CTRL_LOCK_BIT] <= lock_r;
                    hrdata_r[CTRL_SEC_BIT] <= SECURED;
                end
                OFS_DATA:
                begin
                    // Armed, disabled or narrow reads leave zero.
                    if (read_ok && !half_r)
                        hrdata_r[15:0] <= rd_row[15:0];
                    else if (read_ok)
                        hrdata_r[15:0] <= {12'h000, rd_row[19:16]};
                end
                OFS_COUNT:
                begin
                    hrdata_r[CW-1:0] <= count_r;
                    hrdata_r[CNT_ROLL_BIT] <= roll_r;
                end
                default:
                    hrdata_r <= 32'h00000000;
            endcase
        end
    end

    assign HRDATA = hrdata_r;
    assign HREADYOUT = hready_r;
    assign HRESP = hresp_r;
    assign ARMED = arm_r;
endmodule : trace_buffer_format_readout

/* File: dv/core_model.sv */
`timescale 1ns/100ps
module core_model
    import tbuf_pkg::*;
(
    input wire logic clk, // System clock.
    output tbuf_pkg::trace_in_s trace // Capture port toward the buffer.
);
    // ****************************************************************
    // Core capture driver.
    // ****************************************************************
    // Quiet port from time zero.
    initial
    begin
        trace = '0;
    end
    // One capture, then two quiet cycles so a detail data line never collides.
    task automatic send(input trace_in_s t);
        trace <= t;
        @(posedge clk);
        trace.valid <= 1'b0;
        trace.addr <= ~t.addr; // Stale fields must not keep showing the last value.
        trace.data <= ~t.data;
        repeat (2) @(posedge clk);
    endtask : send
    // One-cycle end-of-session pulse.
    task automatic halt;
        trace.stop <= 1'b1;
        @(posedge clk);
        trace.stop <= 1'b0;
    endtask : halt
endmodule : core_model

/* File: dv/tbuf_chk_asserts.sv */
`timescale 1ns/100ps
module tbuf_chk
    import tbuf_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input wire logic MCLK, // Clock.
    input wire logic RESET_N, // Reset, active low.
    input wire logic HSEL, // Select.
    input wire logic [31:0] HADDR, // Address.
    input wire logic [1:0] HTRANS, // Transfer type.
    input wire logic HWRITE, // Write.
    input wire logic [2:0] HSIZE, // Size.
    input wire logic [31:0] HWDATA, // Write data.
    input wire logic HREADY, // Bus ready.
    input wire tbuf_pkg::trace_in_s TRACE_IN, // Capture port.
    input wire logic SECURED, // Secured.
    input wire logic [31:0] HRDATA, // Read data.
    input wire logic HREADYOUT, // Slave ready.
    input wire logic HRESP, // Response.
    input wire logic ARMED // Session running.
);
    // ****************************************************************
    // Bus decode helpers and properties.
    // ****************************************************************
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    logic tk;
    logic dpa;
    // Taken transfers, and taken reads of the data port word.
    assign tk = HSEL && HTRANS[1] && HREADY;
    assign dpa = tk && !HWRITE && HADDR[7:2] == 6'h01;
    sequence ctrl_wr_s;
        tk && HWRITE && HADDR[7:0] == OFS_CTRL ##1 1'b1;
    endsequence
    sequence armed_rd_s;
        dpa && ARMED ##1 ARMED;
    endsequence
    wait_one_a: assert property (tk |=> !HREADYOUT ##1 HREADYOUT)
        else $error("wait state not exactly one cycle");
    ready_idle_a: assert property (HREADYOUT && !tk |=> HREADYOUT)
        else $error("ready dropped without a transfer");
    resp_okay_a: assert property (HRESP == 1'b0)
        else $error("response not okay");
    armed_zero_a: assert property (armed_rd_s |-> ##1 HRDATA == 32'h0)
        else $error("armed read returned data");
    secure_zero_a: assert property (dpa && SECURED ##1 SECURED |-> ##1 HRDATA == 32'h0)
        else $error("secured read returned data");
    size_zero_a: assert property (dpa && (HSIZE != HSIZE_WORD || HADDR[1:0] != 2'h0)
        |-> ##2 HRDATA == 32'h0)
        else $error("byte or misaligned read returned data");
    upper_zero_a: assert property (dpa |-> ##2 HRDATA[31:16] == 16'h0)
        else $error("data port upper half not zero");
    unmapped_zero_a: assert property (tk && !HWRITE && HADDR[7:0] > 8'h0f |-> ##2 HRDATA == 32'h0)
        else $error("unmapped read returned data");
    arm_write_a: assert property (ctrl_wr_s |=> ARMED == $past(HWDATA[CTRL_ARM_BIT]))
        else $error("arm bit write not reflected");
    stop_clear_a: assert property (TRACE_IN.stop && ARMED && HREADYOUT |=> !ARMED)
        else $error("stop pulse did not disarm");
endmodule : tbuf_chk

bind trace_buffer_format_readout tbuf_chk #(.DEPTH(DEPTH)) chk (.MCLK(MCLK), .RESET_N(RESET_N),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADY), .TRACE_IN(TRACE_IN), .SECURED(SECURED),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ARMED(ARMED));

/* File: dv/tb.sv */
`timescale 1ns/100ps
module tb;
    import tbuf_pkg::*;
    // ****************************************************************
    // Wiring and helpers.
    // ****************************************************************
    localparam int DEPTH = 8;
    localparam logic [31:0] ALL = 32'hffffffff;
    localparam logic [2:0] W = HSIZE_WORD;
    typedef struct packed {
        trace_mode_e m;
        logic [17:0] a;
        logic [15:0] d;
        logic [3:0] f;
        logic [19:0] row;
        logic [15:0] dl;
        logic [6:0] cnt;
    } case_s;
    // Per mode: capture fields {rd, byte, dest, vect}, stored row, data line, line count.
    case_s rows [5] = '{
        '{MODE_NORMAL, 18'h2a5c3, 16'h0, 4'b0010, 20'ha_a5c3, 16'h0, 7'h1},
        '{MODE_LOOP, 18'h10f0e, 16'h0, 4'b0001, 20'hd_0f0e, 16'h0, 7'h1},
        '{MODE_NORMAL, 18'h31234, 16'h0, 4'b0000, 20'h3_1234, 16'h0, 7'h1},
        '{MODE_DETAIL, 18'h20040, 16'hab5c, 4'b1100, 20'he_0040, 16'h005c, 7'h2},
        '{MODE_DETAIL, 18'h18001, 16'h1234, 4'b0000, 20'h1_8001, 16'h1234, 7'h2}};
    logic [31:0] cw [8] = '{32'h2345, 32'h1, 32'h81c6, 32'hc, 32'h9, 32'h4, 32'h2000, 32'h2};
    logic [31:0] cm [8] = '{ALL, ALL, ALL, ALL, 32'h3f, 32'hc, ALL, ALL};
    logic mclk, reset_n, hsel, hwrite, secured, hreadyout, hresp, armed;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    trace_in_s trace;
    int bad_count = 0;
    int n_checks = 0;
    trace_buffer_format_readout #(.DEPTH(DEPTH)) dut (.MCLK(mclk), .RESET_N(reset_n),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .TRACE_IN(trace), .SECURED(secured),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .ARMED(armed));
    core_model core (.clk(mclk), .trace(trace));
    // Free-running 250 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // The bus ready is sampled at each rising edge; a stuck slave ends the run.
    task automatic wait_rdy;
        int i;
        i = 0;
        do
        begin
            @(posedge mclk);
            i++;
        end
        while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1)
        begin
            bad_count++;
            complete_run();
        end
    endtask : wait_rdy
    // One single transfer: address phase, then data phase; read data taken at its end.
    task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= sz;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, W, d, r);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [2:0] sz, input logic [31:0] m,
        input logic [31:0] e);
        bus(1'b0, a, sz, 32'h0, r);
        chk(r & m, e);
    endtask : rchk
    task automatic pc(input logic [17:0] a);
        core.send(trace_in_s'{1'b1, 1'b0, a, 16'h0, 1'b0, 1'b0, 1'b0, 1'b0});
    endtask : pc
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        {hsel, hwrite, secured, reset_n} = 4'h0;
        {haddr, hwdata, htrans, hsize} = '0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        foreach (rows[i])
        begin
            wr(OFS_CTRL, {28'h0, rows[i].m, 2'b11});
            core.send({1'b1, 1'b0, rows[i].a, rows[i].d, rows[i].f});
            wr(OFS_CTRL, {28'h0, rows[i].m, 2'b10});
            wr(OFS_DATA, 32'h0);
            rchk(OFS_COUNT, W, 32'h7f, {25'h0, rows[i].cnt});
            rchk(OFS_DATA, W, ALL, {16'h0, rows[i].row[15:0]});
            rchk(OFS_DATA, W, ALL, {28'h0, rows[i].row[19:16]});
            if (rows[i].m == MODE_DETAIL)
                rchk(OFS_DATA, W, ALL, {16'h0, rows[i].dl});
            $display("row %0d done", i);
        end
        // Refused reads leave the pointer where it was.
        wr(OFS_DATAH, 32'h0);
        rchk(OFS_DATA, 3'h1, ALL, 32'h0);
        rchk(8'h06, W, ALL, 32'h0);
        rchk(OFS_DATA, W, ALL, 32'h8001);
        secured <= 1'b1;
        rchk(OFS_DATA, W, ALL, 32'h0);
        secured <= 1'b0;
        wr(OFS_CTRL, {28'h0, MODE_DETAIL, 2'b00});
        rchk(OFS_DATA, W, ALL, 32'h0);
        wr(8'h10, ALL);
        rchk(8'h10, W, ALL, 32'h0);
        rchk(OFS_CTRL, W, ALL, 32'h8);
        $display("refusal test done");
        // Compressed rows, with an armed read refused on the way.
        wr(OFS_CTRL, {28'h0, MODE_COMP, 2'b11});
        for (int k = 0; k < 5; k++)
            pc(18'h12345 + 18'(k));
        pc(18'h22000);
        rchk(OFS_DATA, W, ALL, 32'h0);
        wr(OFS_CTRL, {28'h0, MODE_COMP, 2'b10});
        wr(OFS_DATA, 32'h0);
        rchk(OFS_COUNT, W, 32'h807f, 32'h4);
        for (int k = 0; k < 8; k++)
            rchk(OFS_DATA, W, cm[k], cw[k]);
        $display("compressed test done");
        // Compressed wrap: line zero takes a fresh base, the oldest line is part refilled.
        wr(OFS_CTRL, {28'h0, MODE_COMP, 2'b11});
        for (int k = 0; k < 24; k++)
            pc(18'h200 + 18'(k));
        wr(OFS_CTRL, {28'h0, MODE_COMP, 2'b10});
        wr(OFS_DATA, 32'h0);
        rchk(OFS_COUNT, W, 32'h807f, 32'h8008);
        rchk(OFS_DATA, W, ALL, 32'h3097);
        rchk(OFS_DATA, W, ALL, 32'h4);
        for (int n = 2; n < 8; n++)
        begin
            rchk(OFS_DATA, W, ALL, 32'((3 * n) % 16 * 4096 + (3 * n - 1) * 64 + 3 * n - 2));
            rchk(OFS_DATA, W, ALL, 32'(12 + 3 * n / 16));
        end
        rchk(OFS_DATA, W, ALL, 32'h216);
        rchk(OFS_DATA, W, ALL, 32'h0);
        $display("compressed wrap test done");
        // Ten entries into eight lines: oldest first, then the pointer wraps.
        wr(OFS_CTRL, {28'h0, MODE_NORMAL, 2'b11});
        for (int k = 0; k < 10; k++)
            pc(18'h100 + 18'(k));
        core.halt();
        @(posedge mclk);
        chk({31'h0, armed}, 32'h0);
        wr(OFS_DATA, 32'h0);
        rchk(OFS_COUNT, W, 32'h807f, 32'h8008);
        for (int k = 0; k < 9; k++)
        begin
            rchk(OFS_DATA, W, ALL, 32'h102 + 32'(k % 8));
            rchk(OFS_DATA, W, ALL, 32'h0);
        end
        wr(OFS_DATAH, 32'h0);
        rchk(OFS_DATA, W, ALL, 32'h102);
        rchk(OFS_COUNT, W, 32'h807f, 32'h8008);
        $display("rollover test done");
        // A reset in mid-life keeps contents and count; only a word write unlocks.
        reset_n <= 1'b0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rchk(OFS_CTRL, W, ALL, 32'h10);
        wr(OFS_CTRL, {28'h0, MODE_NORMAL, 2'b10});
        bus(1'b1, OFS_DATA, 3'h0, 32'h0, r);
        rchk(OFS_DATA, W, ALL, 32'h0);
        wr(OFS_DATA, 32'h0);
        rchk(OFS_COUNT, W, 32'h807f, 32'h8008);
        rchk(OFS_DATA, W, ALL, 32'h102);
        $display("reset test done");
        complete_run();
    end
endmodule : tb
